// ---- hdl/rsc_top.sv ----
`timescale 1ns/1ps
`include "rsc_defs.svh"
module rsc_top
  import rsc_pkg::*;
#(
  parameter int TICK_CYCLES = `RSC_TICK_CYC,
  parameter int ACK_CYCLES = `RSC_ACK_CYC,
  parameter int GW = 8,
  parameter int HW = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic nap_request_pin,
  input wire logic tx_busy,
  input wire logic rx_busy,
  input wire logic assoc_busy,
  input wire logic serial_act,
  input wire logic rf_act,
  input wire logic associated,
  output logic cts_n,
  output logic awake_ind,
  output logic poll_go,
  input wire logic frm_req,
  input wire logic frm_bcast,
  input wire logic frm_ack,
  output logic frm_go,
  output logic ack_fail,
  input wire logic [GW-1:0] gpio_level,
  output logic [GW-1:0] gpio_out,
  input wire logic msg_valid,
  output logic msg_ready,
  input wire logic [15:0] msg_addr,
  input wire logic [HW-1:0] msg_handle,
  input wire logic peer_valid,
  input wire logic peer_poll,
  input wire logic [15:0] peer_addr,
  output logic dlv_go,
  output logic dlv_held,
  output logic [15:0] dlv_addr,
  output logic [HW-1:0] dlv_handle
);
  localparam int NS = `RSC_SLOTS;
  localparam int SW = 3;

  logic [31:0] ctrl_r;
  logic [15:0] idle_time_r, nap_int_r, dnap_int_r, bit_cyc_r;
  logic [31:0] prdata_r;
  logic early_r, fpoll_r;
  logic [7:0] ack_fail_cnt_r, drop_cnt_r;
  rsc_state_t state_r, state_nxt;
  logic cts_n_r, awake_r, poll_r, pin_prev_r, pin_woken_r;
  logic [15:0] idle_cnt_r, nap_cnt_r, direct_cnt_r, direct_addr_r;
  logic [31:0] tick_cnt_r;
  logic tick;
  logic [23:0] guard_cnt_r;
  logic guard_on_r;
  logic frm_busy_r, frm_go_r, ack_fail_r;
  logic [1:0] try_cnt_r;
  logic [31:0] ack_cnt_r;
  logic [GW-1:0] gpio_r;
  logic [NS-1:0] slot_v_r;
  logic [15:0] slot_addr_r [NS];
  logic [15:0] slot_age_r [NS];
  logic held_pend_r, dlv_go_r, dlv_held_r;
  logic [15:0] held_addr_r, dlv_addr_r;
  logic [HW-1:0] dlv_handle_r;

  rsc_mem_if #(.AW(SW), .DW(HW)) mif ();
  rsc_msg_store #(.DEPTH(NS), .AW(SW), .DW(HW)) u_store (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .m(mif.mem)
  );

  // apb decode
  logic apb_wr, apb_setup, addr_ok;
  assign apb_wr = psel && penable && pwrite && ce;
  assign apb_setup = psel && !penable && ce;
  assign addr_ok = paddr == `RSC_A_CTRL || paddr == `RSC_A_FPOLL ||
                   paddr == `RSC_A_IDLE || paddr == `RSC_A_NAP ||
                   paddr == `RSC_A_DNAP || paddr == `RSC_A_BIT ||
                   paddr == `RSC_A_STAT;
  assign pready = ce;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata = prdata_r;

  logic [2:0] mode;
  logic mode_pin, mode_cyc, coord;
  assign mode = ctrl_r[`RSC_F_MODE];
  assign mode_pin = mode == `RSC_SM_PIN || mode == `RSC_SM_CYCPIN; // [R04]
  assign mode_cyc = mode == `RSC_SM_CYC || mode == `RSC_SM_CYCPIN; // [R04]
  assign coord = ctrl_r[`RSC_F_COORD];

  logic [SW-1:0] pend_cnt;
  always_comb begin
    pend_cnt = '0;
    for (int i = 0; i < NS; i++) begin
      pend_cnt = pend_cnt + SW'(slot_v_r[i]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `RSC_CTRL_RST;
      idle_time_r <= `RSC_IDLE_RST;
      nap_int_r <= `RSC_NAP_RST;
      dnap_int_r <= `RSC_DNAP_RST;
      bit_cyc_r <= `RSC_BIT_RST;
    end else if (apb_wr) begin
      case (paddr)
        `RSC_A_CTRL: ctrl_r <= pwdata;
        `RSC_A_IDLE: idle_time_r <= pwdata[`RSC_F_T16];
        `RSC_A_NAP: nap_int_r <= pwdata[`RSC_F_T16];
        `RSC_A_DNAP: dnap_int_r <= pwdata[`RSC_F_T16];
        `RSC_A_BIT: bit_cyc_r <= pwdata[`RSC_F_T16];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
    end else if (apb_setup && !pwrite) begin
      case (paddr)
        `RSC_A_CTRL: prdata_r <= ctrl_r;
        `RSC_A_IDLE: prdata_r <= {16'h0, idle_time_r};
        `RSC_A_NAP: prdata_r <= {16'h0, nap_int_r};
        `RSC_A_DNAP: prdata_r <= {16'h0, dnap_int_r};
        `RSC_A_BIT: prdata_r <= {16'h0, bit_cyc_r};
        `RSC_A_STAT: prdata_r <= {8'h0, drop_cnt_r, ack_fail_cnt_r, 1'b0,
                                  pend_cnt, early_r, pin_woken_r, state_r};
        default: prdata_r <= '0;
      endcase
    end
  end

  // force poll command, one-cycle pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fpoll_r <= 1'b0;
    end else if (ce) begin
      fpoll_r <= apb_wr && paddr == `RSC_A_FPOLL && pwdata[0];
    end
  end

  // millisecond tick for all interval timers
  assign tick = tick_cnt_r == 32'(TICK_CYCLES - 1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= '0;
    end else if (ce) begin
      tick_cnt_r <= tick ? '0 : tick_cnt_r + 32'h1;
    end
  end

  logic activity, work_busy, pin_fall, nap_due, idle_due, pin_sleep;
  logic [15:0] nap_int;
  assign work_busy = tx_busy || rx_busy || assoc_busy || frm_busy_r;
  assign activity = work_busy || serial_act || rf_act;
  assign pin_fall = pin_prev_r && !nap_request_pin; // [R14]
  assign nap_int = associated ? nap_int_r : dnap_int_r;
  assign nap_due = nap_cnt_r >= nap_int;
  assign idle_due = mode_cyc && idle_cnt_r >= idle_time_r; // [R03]
  assign pin_sleep = nap_request_pin && mode_pin &&
                     !(mode == `RSC_SM_CYCPIN && pin_woken_r); // [R02] [R13]

  logic wake_cyc, wake_pin;
  always_comb begin
    state_nxt = state_r;
    wake_cyc = 1'b0;
    wake_pin = 1'b0;
    case (state_r)
      st_awake: begin
        if (pin_sleep || idle_due) begin // [R01]
          state_nxt = st_drain;
        end
      end
      st_drain: begin
        if (mode == `RSC_SM_PIN && !nap_request_pin) begin
          state_nxt = st_awake;
        end else if (!work_busy) begin // [R05]
          state_nxt = st_idle;
        end
      end
      st_idle: state_nxt = st_sleep; // [R05]
      st_sleep: begin
        // serial and radio inputs are not looked at here [R06]
        if (!mode_pin && !mode_cyc) begin // [R01]
          state_nxt = st_awake;
        end else if (mode == `RSC_SM_PIN) begin
          if (!nap_request_pin) begin // [R07] [R14]
            state_nxt = st_awake;
            wake_pin = 1'b1;
          end
        end else if (mode == `RSC_SM_CYCPIN && pin_fall) begin // [R11]
          state_nxt = st_awake;
          wake_pin = 1'b1;
        end else if (nap_due) begin // [R09]
          state_nxt = st_awake;
          wake_cyc = 1'b1;
        end
      end
      default: state_nxt = st_awake;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= st_awake;
      cts_n_r <= 1'b0;
      awake_r <= 1'b1;
      poll_r <= 1'b0;
      pin_prev_r <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
      // [R07] [R10] [R15]
      cts_n_r <= ctrl_r[`RSC_F_FLOW] && state_nxt != st_awake;
      awake_r <= state_nxt != st_sleep; // [R10] [R15]
      poll_r <= wake_cyc || fpoll_r ||
                (wake_pin && ctrl_r[`RSC_F_ASSOC][`RSC_POLL_BIT]); // [R21]
      pin_prev_r <= nap_request_pin;
    end
  end
  assign cts_n = cts_n_r;
  assign awake_ind = awake_r;
  assign poll_go = poll_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_woken_r <= 1'b0;
    end else if (ce) begin
      if (state_nxt == st_sleep) begin
        pin_woken_r <= 1'b0;
      end else if (wake_pin && mode == `RSC_SM_CYCPIN) begin
        pin_woken_r <= 1'b1; // [R13]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_cnt_r <= '0;
      nap_cnt_r <= '0;
    end else if (ce) begin
      if (state_r != st_awake || activity) begin
        idle_cnt_r <= '0; // [R12]
      end else if (tick && idle_cnt_r != 16'hffff) begin
        idle_cnt_r <= idle_cnt_r + 16'h1;
      end
      if (state_r != st_sleep) begin
        nap_cnt_r <= '0;
      end else if (tick && !nap_due) begin
        nap_cnt_r <= nap_cnt_r + 16'h1;
      end
    end
  end

  // wake guard: pin must stay low two byte times after cts falls
  logic [23:0] guard_lim;
  assign guard_lim = 24'(bit_cyc_r) * 24'(`RSC_BYTE_BITS) *
                     24'(`RSC_GUARD_BYTES); // [R23]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      guard_on_r <= 1'b0;
      guard_cnt_r <= '0;
      early_r <= 1'b0;
    end else if (ce) begin
      if (wake_pin && mode == `RSC_SM_PIN) begin
        guard_on_r <= 1'b1;
        guard_cnt_r <= '0;
      end else if (guard_on_r) begin
        guard_cnt_r <= guard_cnt_r + 24'h1;
        if (guard_cnt_r >= guard_lim || nap_request_pin) begin
          guard_on_r <= 1'b0;
        end
      end
      if (guard_on_r && nap_request_pin && guard_cnt_r < guard_lim) begin
        early_r <= 1'b1; // [R08]
      end else if (apb_wr && paddr == `RSC_A_STAT && pwdata[`RSC_S_EARLY]) begin
        early_r <= 1'b0;
      end
    end
  end

  // outputs keep their level through sleep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpio_r <= '0;
    end else if (ce && state_r != st_sleep) begin
      gpio_r <= gpio_level; // [R16]
    end
  end
  assign gpio_out = gpio_r;

  // frame engine with acknowledge retries
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frm_busy_r <= 1'b0;
      frm_go_r <= 1'b0;
      ack_fail_r <= 1'b0;
      try_cnt_r <= '0;
      ack_cnt_r <= '0;
      ack_fail_cnt_r <= '0;
    end else if (ce) begin
      frm_go_r <= 1'b0;
      ack_fail_r <= 1'b0;
      if (!frm_busy_r) begin
        if (frm_req && state_r == st_awake) begin
          frm_go_r <= 1'b1;
          frm_busy_r <= !frm_bcast; // [R22]
          try_cnt_r <= '0;
          ack_cnt_r <= '0;
        end
      end else if (frm_ack) begin
        frm_busy_r <= 1'b0;
      end else if (ack_cnt_r == 32'(ACK_CYCLES - 1)) begin
        ack_cnt_r <= '0;
        if (try_cnt_r == `RSC_RETRIES) begin // [R22]
          frm_busy_r <= 1'b0;
          ack_fail_r <= 1'b1;
          ack_fail_cnt_r <= ack_fail_cnt_r + 8'h1;
        end else begin
          try_cnt_r <= try_cnt_r + 2'h1;
          frm_go_r <= 1'b1;
        end
      end else begin
        ack_cnt_r <= ack_cnt_r + 32'h1;
      end
    end
  end
  assign frm_go = frm_go_r;
  assign ack_fail = ack_fail_r;

  // coordinator: direct window after addressed traffic
  logic direct_live, peer_addr_hit;
  assign peer_addr_hit = peer_valid && peer_addr != `RSC_BCAST;
  assign direct_live = direct_cnt_r < idle_time_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      direct_addr_r <= '0;
      direct_cnt_r <= 16'hffff;
    end else if (ce) begin
      if (peer_addr_hit) begin // [R19]
        direct_addr_r <= peer_addr;
        direct_cnt_r <= '0;
      end else if (tick && direct_cnt_r != 16'hffff) begin
        direct_cnt_r <= direct_cnt_r + 16'h1;
      end
    end
  end

  logic accept, go_held, free_ok, hit_ok;
  logic [SW-1:0] free_idx, hit_idx;
  always_comb begin
    free_ok = 1'b0;
    free_idx = '0;
    hit_ok = 1'b0;
    hit_idx = '0;
    for (int i = NS - 1; i >= 0; i--) begin
      if (!slot_v_r[i]) begin
        free_ok = 1'b1;
        free_idx = SW'(i);
      end
      if (slot_v_r[i] && slot_addr_r[i] == peer_addr) begin
        hit_ok = peer_valid && peer_poll;
        hit_idx = SW'(i);
      end
    end
  end
  assign msg_ready = ce && !held_pend_r;
  assign accept = msg_valid && msg_ready;
  assign go_held = coord && nap_int_r != 16'h0 && msg_addr != `RSC_BCAST &&
                   !(direct_live && msg_addr == direct_addr_r); // [R17] [R18]

  assign mif.we = accept && go_held && free_ok; // [R17]
  assign mif.waddr = free_idx;
  assign mif.wdata = msg_handle;
  assign mif.re = hit_ok && ce;
  assign mif.raddr = hit_idx;

  generate
    for (genvar g = 0; g < NS; g++) begin : g_slot
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          slot_v_r[g] <= 1'b0;
          slot_addr_r[g] <= '0;
          slot_age_r[g] <= '0;
        end else if (ce) begin
          if (mif.we && free_idx == SW'(g)) begin
            slot_v_r[g] <= 1'b1;
            slot_addr_r[g] <= msg_addr;
            slot_age_r[g] <= '0;
          end else if (hit_ok && hit_idx == SW'(g)) begin
            slot_v_r[g] <= 1'b0;
          end else if (slot_v_r[g] && slot_age_r[g] >= nap_int_r) begin
            slot_v_r[g] <= 1'b0; // [R20]
          end else if (slot_v_r[g] && tick) begin
            slot_age_r[g] <= slot_age_r[g] + 16'h1;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held_pend_r <= 1'b0;
      held_addr_r <= '0;
      dlv_go_r <= 1'b0;
      dlv_held_r <= 1'b0;
      dlv_addr_r <= '0;
      dlv_handle_r <= '0;
      drop_cnt_r <= '0;
    end else if (ce) begin
      held_pend_r <= hit_ok;
      if (hit_ok) begin
        held_addr_r <= peer_addr;
      end
      dlv_go_r <= held_pend_r || (accept && !go_held);
      dlv_held_r <= held_pend_r;
      if (held_pend_r) begin
        dlv_addr_r <= held_addr_r;
        dlv_handle_r <= mif.rdata;
      end else if (accept && !go_held) begin // [R18]
        dlv_addr_r <= msg_addr;
        dlv_handle_r <= msg_handle;
      end
      if (accept && go_held && !free_ok) begin
        drop_cnt_r <= drop_cnt_r + 8'h1;
      end
    end
  end
  assign dlv_go = dlv_go_r;
  assign dlv_held = dlv_held_r;
  assign dlv_addr = dlv_addr_r;
  assign dlv_handle = dlv_handle_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_OFF_WAKES: assert property ( // [R01]
    ce && state_r == st_sleep && mode == `RSC_SM_OFF |=> state_r == st_awake)
    else $error("mode zero left device asleep");
  AST_PIN_SLEEP: assert property ( // [R02]
    ce && state_r == st_awake && nap_request_pin && mode == `RSC_SM_PIN
    |=> state_r == st_drain)
    else $error("pin request did not start sleep");
  AST_NO_IDLE_M1: assert property ( // [R03]
    ce && state_r == st_awake && mode == `RSC_SM_PIN && !nap_request_pin
    |=> state_r == st_awake)
    else $error("idle timer slept in pin mode");
  AST_DRAIN: assert property ( // [R05]
    ce && state_r == st_drain && work_busy && mode != `RSC_SM_PIN
    |=> state_r == st_drain ##0 (ce [*1] or !ce))
    else $error("sleep entered with work pending");
  AST_IDLE_SLEEP: assert property ( // [R05]
    ce && state_r == st_idle |=> state_r == st_sleep && !awake_ind)
    else $error("idle did not lead to sleep");
  AST_IGNORE: assert property ( // [R06]
    ce && state_r == st_sleep && mode == `RSC_SM_PIN && nap_request_pin
    |=> state_r == st_sleep)
    else $error("pin sleep woke on traffic");
  AST_CYC_POLL: assert property ( // [R09]
    ce && state_r == st_sleep && mode == `RSC_SM_CYC && nap_due
    |=> poll_go && awake_ind)
    else $error("periodic wake without poll");
  AST_CTS: assert property ( // [R15]
    ce && ctrl_r[`RSC_F_FLOW] && $past(ctrl_r[`RSC_F_FLOW])
    |-> cts_n == (state_r != st_awake) && awake_ind == (state_r != st_sleep))
    else $error("cts or awake pin wrong");
  AST_HOLD: assert property ( // [R16]
    state_r == st_sleep && $past(state_r) == st_sleep |-> $stable(gpio_out))
    else $error("output pin moved during sleep");
  AST_HELD_COORD: assert property ( // [R17]
    mif.we |-> coord && pend_cnt < SW'(NS))
    else $error("held message without room or role");
  AST_ACK_FAIL: assert property ( // [R22]
    ack_fail |-> $past(try_cnt_r) == `RSC_RETRIES)
    else $error("ack failure before three resends");

  COV_SLEEP: cover property (state_r == st_idle ##1 state_r == st_sleep);
  COV_CYC: cover property (state_r == st_sleep ##1 poll_go);
  COV_HELD: cover property (dlv_go && dlv_held);
  COV_FAIL: cover property (ack_fail);
endmodule : rsc_top

// ---- hdl/rsc_defs.svh ----
// Function
// [R01] sleep needs nonzero mode plus a cause
// [R02] pin asserted in modes 1/5 sleeps
// [R03] idle timeout sleeps, modes 4/5 only
// [R04] mode codes 0, 1, 4, 5 decoded
// [R05] finish work, pass idle, then sleep
// [R06] pin sleep ignores serial and radio
// [R07] pin release wakes, clear-to-send low
// [R08] host holds pin low two byte times
// [R09] periodic wake polls coordinator
// [R10] periodic wake: awake high, cts low
// [R11] mode 5 pin low wakes device
// [R12] activity restarts the idle timer
// [R13] after mode 5 pin wake ignore pin
// [R14] mode 1 level, mode 5 falling edge
// [R15] cts and awake pin polarities fixed
// [R16] output pins hold levels while asleep
// [R17] coordinator only, five held messages max
// [R18] zero interval or awake peer: direct
// [R19] addressed traffic opens direct window
// [R20] held message discarded after interval
// [R21] poll on cyclic wake, option, command
// [R22] three resends, then acknowledge failure
// [R23] byte time from bit time, ten bits
`ifndef RSC_DEFS_SVH
`define RSC_DEFS_SVH
`define RSC_A_CTRL 8'h00
`define RSC_A_FPOLL 8'h04
`define RSC_A_IDLE 8'h08
`define RSC_A_NAP 8'h0c
`define RSC_A_DNAP 8'h10
`define RSC_A_BIT 8'h14
`define RSC_A_STAT 8'h18
`define RSC_F_MODE 2:0
`define RSC_F_FLOW 3
`define RSC_F_ASSOC 11:8
`define RSC_F_COORD 12
`define RSC_F_T16 15:0
`define RSC_POLL_BIT 3
`define RSC_S_EARLY 3
`define RSC_SM_OFF 3'h0
`define RSC_SM_PIN 3'h1
`define RSC_SM_CYC 3'h4
`define RSC_SM_CYCPIN 3'h5
`define RSC_CTRL_RST 32'h0000_0008
`define RSC_IDLE_RST 16'h1388
`define RSC_NAP_RST 16'h0064
`define RSC_DNAP_RST 16'h03e8
`define RSC_BIT_RST 16'h0823
`define RSC_BCAST 16'hffff
`define RSC_CLK_NS 50
`define RSC_TICK_NS 1000000
`define RSC_TICK_CYC (`RSC_TICK_NS / `RSC_CLK_NS)
`define RSC_ACK_NS 500000
`define RSC_ACK_CYC (`RSC_ACK_NS / `RSC_CLK_NS)
`define RSC_RETRIES 2'h3
`define RSC_SLOTS 5
`define RSC_BYTE_BITS 5'h0a
`define RSC_GUARD_BYTES 3'h2
`endif

// ---- hdl/rsc_pkg.sv ----
package rsc_pkg;
  typedef enum logic [1:0] {st_awake, st_drain, st_idle, st_sleep} rsc_state_t;
endpackage : rsc_pkg

// ---- hdl/rsc_mem_if.sv ----
`timescale 1ns/1ps
interface rsc_mem_if #(parameter int AW = 3, parameter int DW = 8);
  logic we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic re;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  modport ctl (output we, waddr, wdata, re, raddr, input rdata);
  modport mem (input we, waddr, wdata, re, raddr, output rdata);
endinterface : rsc_mem_if

// ---- hdl/rsc_msg_store.sv ----
`timescale 1ns/1ps
module rsc_msg_store #(
  parameter int DEPTH = 5,
  parameter int AW = 3,
  parameter int DW = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  rsc_mem_if.mem m
);
  logic [DW-1:0] mem_r [DEPTH];
  logic [DW-1:0] rdata_r;

  always_ff @(posedge pclk) begin
    if (ce && m.we) begin
      mem_r[m.waddr] <= m.wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_r <= '0;
    end else if (ce && m.re) begin
      rdata_r <= mem_r[m.raddr];
    end
  end

  assign m.rdata = rdata_r;
endmodule : rsc_msg_store

// ---- testbench/rsc_link_model.sv ----
`timescale 1ns/1ps
module rsc_link_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic frm_go,
  input wire logic [3:0] ack_dly,
  output logic frm_ack
);
  logic [3:0] cnt_r;
  // answers each frame after ack_dly cycles; zero means never
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 4'h0;
      frm_ack <= 1'b0;
    end else begin
      frm_ack <= (cnt_r == 4'h1);
      if (frm_go && ack_dly != 4'h0) begin
        cnt_r <= ack_dly;
      end else if (cnt_r != 4'h0) begin
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end
endmodule : rsc_link_model

// ---- testbench/test_radio_sleep_controller.sv ----
`timescale 1ns/1ps
`include "rsc_defs.svh"
module test_radio_sleep_controller;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic pin = 1'b0;
  logic tx_busy = 1'b0;
  logic act = 1'b0;
  logic frm_req = 1'b0;
  logic frm_bcast = 1'b0;
  logic [3:0] ack_dly = 4'h0;
  logic [7:0] gpio_level = 8'h3c;
  logic msg_valid = 1'b0;
  logic [15:0] msg_addr = 16'h0;
  logic peer_valid = 1'b0;
  logic peer_poll = 1'b0;
  logic [15:0] peer_addr = 16'h0;
  logic [31:0] prdata;
  logic pready, pslverr, cts_n, awake_ind, poll_go, frm_go, frm_ack;
  logic ack_fail, dlv_go, dlv_held;
  logic [15:0] dlv_addr;
  logic msg_ready;
  logic [7:0] dlv_handle, last_hdl;
  logic [7:0] gpio_out;
  logic [31:0] q;
  logic e;
  logic last_held;
  logic [15:0] last_addr;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  int n_poll = 0;
  int n_go = 0;
  int n_fail = 0;
  int n_dlv = 0;
  int p;
  rsc_top #(.TICK_CYCLES(4), .ACK_CYCLES(8)) u_dut (
    .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .nap_request_pin(pin), .tx_busy(tx_busy), .rx_busy(tx_busy),
    .assoc_busy(act), .serial_act(act), .rf_act(act), .associated(1'b1),
    .cts_n(cts_n), .awake_ind(awake_ind), .poll_go(poll_go),
    .frm_req(frm_req), .frm_bcast(frm_bcast), .frm_ack(frm_ack),
    .frm_go(frm_go), .ack_fail(ack_fail), .gpio_level(gpio_level),
    .gpio_out(gpio_out), .msg_valid(msg_valid), .msg_ready(msg_ready),
    .msg_addr(msg_addr), .msg_handle(msg_addr[7:0]),
    .peer_valid(peer_valid),
    .peer_poll(peer_poll), .peer_addr(peer_addr), .dlv_go(dlv_go),
    .dlv_held(dlv_held), .dlv_addr(dlv_addr), .dlv_handle(dlv_handle));
  rsc_link_model u_link (.pclk(pclk), .presetn(presetn), .frm_go(frm_go),
    .ack_dly(ack_dly), .frm_ack(frm_ack));
  always #25 pclk = ~pclk;
  always @(posedge pclk) begin
    if (poll_go === 1'b1) n_poll++;
    if (frm_go === 1'b1) n_go++;
    if (ack_fail === 1'b1) n_fail++;
    if (dlv_go === 1'b1) begin
      n_dlv++;
      last_held = dlv_held;
      last_addr = dlv_addr;
      last_hdl = dlv_handle;
    end
  end
  task automatic print_verdict;
    if (err_total == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    int i;
    i = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wait_awake(input logic v, input int lim);
    int i;
    i = 0;
    while (awake_ind !== v && i < lim) begin
      @(posedge pclk);
      i++;
    end
    chk(awake_ind, v);
  endtask : wait_awake
  task automatic msg(input logic [15:0] a);
    msg_valid <= 1'b1;
    msg_addr <= a;
    @(posedge pclk);
    msg_valid <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : msg
  task automatic t_regs;
    apb(1'b0, `RSC_A_CTRL, 32'h0);
    chk(q, `RSC_CTRL_RST);
    apb(1'b0, `RSC_A_BIT, 32'h0);
    chk(q, {16'h0, `RSC_BIT_RST});
    apb(1'b0, `RSC_A_NAP, 32'h0);
    chk(q, {16'h0, `RSC_NAP_RST});
    apb(1'b0, 8'h40, 32'h0);
    chk({e, q}, 33'h1_0000_0000);
  endtask : t_regs
  task automatic t_pin;
    pin <= 1'b1;
    repeat (20) @(posedge pclk);
    chk(awake_ind, 1'b1);
    apb(1'b1, `RSC_A_BIT, 32'h2);
    apb(1'b1, `RSC_A_CTRL, 32'h0000_0809);
    tx_busy <= 1'b1;
    repeat (10) @(posedge pclk);
    chk(awake_ind, 1'b1);
    tx_busy <= 1'b0;
    wait_awake(1'b0, 10);
    chk(cts_n, 1'b1);
    act <= 1'b1;
    gpio_level <= 8'hc3;
    repeat (6) @(posedge pclk);
    chk(awake_ind, 1'b0);
    chk(gpio_out, 8'h3c);
    act <= 1'b0;
    p = n_poll;
    pin <= 1'b0;
    wait_awake(1'b1, 5);
    chk(cts_n, 1'b0);
    // host keeps the pin low well past two byte times
    repeat (50) @(posedge pclk);
    chk(n_poll, p + 1);
    apb(1'b0, `RSC_A_STAT, 32'h0);
    chk(q[3], 1'b0);
    apb(1'b1, `RSC_A_FPOLL, 32'h1);
    repeat (2) @(posedge pclk);
    chk(n_poll, p + 2);
  endtask : t_pin
  task automatic t_cyc;
    apb(1'b1, `RSC_A_IDLE, 32'h2);
    apb(1'b1, `RSC_A_NAP, 32'h3);
    act <= 1'b1;
    apb(1'b1, `RSC_A_CTRL, 32'h0000_000c);
    repeat (30) @(posedge pclk);
    chk(awake_ind, 1'b1);
    act <= 1'b0;
    wait_awake(1'b0, 30);
    p = n_poll;
    wait_awake(1'b1, 40);
    chk(cts_n, 1'b0);
    repeat (2) @(posedge pclk);
    chk(n_poll, p + 1);
  endtask : t_cyc
  task automatic t_cycpin;
    apb(1'b1, `RSC_A_NAP, 32'h64);
    apb(1'b1, `RSC_A_CTRL, 32'h0000_000d);
    wait_awake(1'b0, 30);
    pin <= 1'b1;
    repeat (10) @(posedge pclk);
    chk(awake_ind, 1'b0);
    pin <= 1'b0;
    wait_awake(1'b1, 4);
    pin <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(awake_ind, 1'b1);
    wait_awake(1'b0, 30);
    pin <= 1'b0;
    wait_awake(1'b1, 4);
    apb(1'b1, `RSC_A_CTRL, 32'h0000_0008);
  endtask : t_cycpin
  task automatic t_frm;
    logic [5:0] tb [3] = '{6'h19, 6'h02, 6'h22};
    int g, f;
    for (int i = 0; i < 3; i++) begin
      g = n_go;
      f = n_fail;
      ack_dly <= tb[i][4] ? 4'h0 : {1'b0, tb[i][5], 2'h3};
      frm_bcast <= tb[i][5];
      frm_req <= 1'b1;
      @(posedge pclk);
      frm_req <= 1'b0;
      repeat (60) @(posedge pclk);
      chk(n_go - g, tb[i][3:1]);
      chk(n_fail - f, tb[i][0]);
    end
  endtask : t_frm
  task automatic t_coord;
    int d;
    d = n_dlv;
    apb(1'b1, `RSC_A_CTRL, 32'h0000_1008);
    msg(16'h0012);
    chk(n_dlv, d);
    msg(`RSC_BCAST);
    chk({n_dlv[7:0], last_held}, {d[7:0] + 8'h1, 1'b0});
    peer_valid <= 1'b1;
    peer_poll <= 1'b1;
    peer_addr <= 16'h0012;
    @(posedge pclk);
    peer_valid <= 1'b0;
    repeat (4) @(posedge pclk);
    chk({last_held, last_addr, last_hdl}, 25'h100_1212);
    chk(msg_ready, 1'b1);
    msg(16'h0012);
    chk({n_dlv[7:0], last_held}, {d[7:0] + 8'h3, 1'b0});
    repeat (20) @(posedge pclk);
    for (int i = 0; i < 6; i++) msg(16'h0034);
    apb(1'b0, `RSC_A_STAT, 32'h0);
    chk({q[23:16], q[6:4]}, 11'h00d);
    apb(1'b1, `RSC_A_NAP, 32'h3);
    repeat (40) @(posedge pclk);
    apb(1'b0, `RSC_A_STAT, 32'h0);
    chk(q[6:4], 3'h0);
    apb(1'b1, `RSC_A_NAP, 32'h0);
    msg(16'h0056);
    chk({last_held, last_addr, last_hdl}, 25'h000_5656);
  endtask : t_coord
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_pin();
    t_cyc();
    t_cycpin();
    t_frm();
    t_coord();
    print_verdict();
  end
endmodule : test_radio_sleep_controller
